// ===== logic/bsta_cfg.svh
// Purpose: constants of the boundary-scan test access block
// Assumes: tck clocks the scan logic, clk the configuration side
// Notes: instruction codes are plain defaults
`ifndef BSTA_CFG_SVH
`define BSTA_CFG_SVH
`define BSTA_IR_W 4
`define BSTA_IR_CAPTURE 4'h1
`define BSTA_OP_EXTEST 4'h0
`define BSTA_OP_SAMPLE 4'h5
`define BSTA_OP_IDCODE 4'h6
`define BSTA_OP_CFG_INTR 4'hD
`define BSTA_OP_BYPASS 4'hF
`define BSTA_IDCODE_RESET 32'h0ABC_D001
`define BSTA_ID_W 32
// lowest pins that form differential pairs
`define BSTA_DIFF_PINS 2
`endif

// ===== logic/bsta_pkg.sv
package bsta_pkg;
  typedef enum logic [3:0] {
    BSTA_TLR, BSTA_RTI, BSTA_SEL_DR, BSTA_CAP_DR, BSTA_SH_DR, BSTA_EX1_DR, BSTA_PA_DR,
    BSTA_EX2_DR, BSTA_UP_DR, BSTA_SEL_IR, BSTA_CAP_IR, BSTA_SH_IR, BSTA_EX1_IR,
    BSTA_PA_IR, BSTA_EX2_IR, BSTA_UP_IR
  } bsta_tap_t;
endpackage

// ===== logic/bsta_cell_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bsta_cell_if #(parameter int N = 8);
  logic shift_en;
  logic capture_en;
  logic update_en;
  logic scan_in;
  logic scan_out;
  logic [N-1:0] pin_in;
  logic [N-1:0] data_upd;
  logic [N-1:0] oe_upd;
  modport tap (output shift_en, output capture_en, output update_en, output scan_in,
    input scan_out, output pin_in, input data_upd, input oe_upd);
  modport chain (input shift_en, input capture_en, input update_en, input scan_in,
    output scan_out, input pin_in, output data_upd, output oe_upd);
endinterface
`default_nettype wire

// ===== logic/bsta_cells.sv
// Purpose: boundary register: capture/shift stage and update stage per pin
// Assumes: runs on tck, one data and one enable cell per pin
// Notes: enable update 0 means drive
`timescale 1ns/100ps
`default_nettype none
module bsta_cells #(
  parameter int N = 8
) (
  input wire logic tck,
  input wire logic trst,
  bsta_cell_if.chain cif
);
  logic [2*N-1:0] sh_q;
  logic [N-1:0] dat_q;
  logic [N-1:0] oe_q;
  wire logic [N-1:0] nxt_w;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cell
      // chain runs top data, top enable, next data, next enable, down to pin 0
      if (i == N-1) begin : g_head
        assign nxt_w[i] = cif.scan_in;
      end else begin : g_link
        assign nxt_w[i] = sh_q[2*i+3];
      end
      always_ff @(posedge tck) begin
        if (cif.capture_en) begin
          sh_q[2*i] <= cif.pin_in[i];
          sh_q[2*i+1] <= oe_q[i];
        end else if (cif.shift_en) begin
          sh_q[2*i] <= nxt_w[i];
          sh_q[2*i+1] <= sh_q[2*i];
        end
      end
      always_ff @(negedge tck) begin
        if (trst) begin
          dat_q[i] <= 1'b0;
          oe_q[i] <= 1'b1;
        end else if (cif.update_en) begin
          dat_q[i] <= sh_q[2*i];
          oe_q[i] <= sh_q[2*i+1];
        end
      end
    end
  endgenerate

  assign cif.scan_out = sh_q[1];
  assign cif.data_upd = dat_q;
  assign cif.oe_upd = oe_q;
endmodule // bsta_cells
`default_nettype wire

// ===== logic/bsta_top.sv
// Purpose: tap controller, instruction decode, pin control, config interlock
// Assumes: tck is the link clock; clk runs configuration side at 50 MHz
// Notes: tdo changes on falling tck; pin oe low means drive
`timescale 1ns/100ps
`default_nettype none
`include "bsta_cfg.svh"
module bsta_top
  import bsta_pkg::*;
#(
  parameter int N = 8,
  parameter logic [31:0] ID_VALUE = `BSTA_IDCODE_RESET // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic config_busy,
  input wire logic configured,
  input wire logic [N-1:0] core_out,
  input wire logic [N-1:0] core_oe_n,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe_n,
  output logic config_stop,
  output logic extest_refused
);
  bsta_tap_t st_q;
  bsta_tap_t st_d;
  logic [`BSTA_IR_W-1:0] ir_sh_q;
  logic [`BSTA_IR_W-1:0] ir_q;
  logic [`BSTA_ID_W-1:0] id_q;
  logic byp_q;
  logic in_tlr;
  logic refused_tck_q;
  logic upd_tgl_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic ext_s3_q;
  logic upd_load;
  logic [N-1:0] pin_s1_q;
  logic [N-1:0] pin_s2_q;
  wire logic [N-1:0] pin_cap;
  logic busy_s1_q;
  logic busy_s2_q;
  logic cfgd_s1_q;
  logic cfgd_s2_q;
  logic ext_tck_q;
  logic intr_tck_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic intr_s1_q;
  logic intr_s2_q;
  logic busy_c1_q;
  logic busy_c2_q;
  logic is_extest;
  logic is_idcode;
  logic is_bsr;
  logic sel_tdo;

  bsta_cell_if #(.N(N)) cif ();

  assign in_tlr = (st_q == BSTA_TLR);

  bsta_cells #(.N(N)) u_cells (
    .tck(tck),
    .trst(in_tlr),
    .cif(cif)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      BSTA_TLR: st_d = tms ? BSTA_TLR : BSTA_RTI;
      BSTA_RTI: st_d = tms ? BSTA_SEL_DR : BSTA_RTI;
      BSTA_SEL_DR: st_d = tms ? BSTA_SEL_IR : BSTA_CAP_DR;
      BSTA_CAP_DR: st_d = tms ? BSTA_EX1_DR : BSTA_SH_DR;
      BSTA_SH_DR: st_d = tms ? BSTA_EX1_DR : BSTA_SH_DR;
      BSTA_EX1_DR: st_d = tms ? BSTA_UP_DR : BSTA_PA_DR;
      BSTA_PA_DR: st_d = tms ? BSTA_EX2_DR : BSTA_PA_DR;
      BSTA_EX2_DR: st_d = tms ? BSTA_UP_DR : BSTA_SH_DR;
      BSTA_UP_DR: st_d = tms ? BSTA_SEL_DR : BSTA_RTI;
      BSTA_SEL_IR: st_d = tms ? BSTA_TLR : BSTA_CAP_IR;
      BSTA_CAP_IR: st_d = tms ? BSTA_EX1_IR : BSTA_SH_IR;
      BSTA_SH_IR: st_d = tms ? BSTA_EX1_IR : BSTA_SH_IR;
      BSTA_EX1_IR: st_d = tms ? BSTA_UP_IR : BSTA_PA_IR;
      BSTA_PA_IR: st_d = tms ? BSTA_EX2_IR : BSTA_PA_IR;
      BSTA_EX2_IR: st_d = tms ? BSTA_UP_IR : BSTA_SH_IR;
      BSTA_UP_IR: st_d = tms ? BSTA_SEL_DR : BSTA_RTI;
      default: st_d = BSTA_TLR;
    endcase
  end

  // tap state is reset by tms alone, as on a real port with no reset pin
  always_ff @(posedge tck) begin
    st_q <= st_d;
  end

  // instruction shifter loads the fixed capture pattern
  always_ff @(posedge tck) begin
    if (st_q == BSTA_CAP_IR) begin
      ir_sh_q <= `BSTA_IR_CAPTURE;
    end else if (st_q == BSTA_SH_IR) begin
      ir_sh_q <= {tdi, ir_sh_q[`BSTA_IR_W-1:1]};
    end
  end

  // busy config level crossed into tck domain
  always_ff @(posedge tck) begin
    busy_s1_q <= config_busy;
    busy_s2_q <= busy_s1_q;
  end

  // configured level crossed into tck domain
  always_ff @(posedge tck) begin
    cfgd_s1_q <= configured;
    cfgd_s2_q <= cfgd_s1_q;
  end

  always_ff @(negedge tck) begin
    if (in_tlr) begin
      ir_q <= `BSTA_OP_IDCODE;
    end else if (st_q == BSTA_UP_IR) begin
      if (ir_sh_q == `BSTA_OP_EXTEST && busy_s2_q && !intr_tck_q) begin
        ir_q <= `BSTA_OP_BYPASS;
      end else begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // refusal flag follows the last instruction load; a refused extest parks on bypass
  always_ff @(negedge tck) begin
    if (in_tlr) begin
      refused_tck_q <= 1'b0;
    end else if (st_q == BSTA_UP_IR) begin
      refused_tck_q <= (ir_sh_q == `BSTA_OP_EXTEST) && busy_s2_q && !intr_tck_q;
    end
  end

  // configuration interrupt stays latched until tap reset
  always_ff @(negedge tck) begin
    if (st_q == BSTA_TLR) begin
      intr_tck_q <= 1'b0;
    end else if (st_q == BSTA_UP_IR && ir_sh_q == `BSTA_OP_CFG_INTR) begin
      intr_tck_q <= 1'b1;
    end
  end

  assign is_extest = (ir_q == `BSTA_OP_EXTEST);
  assign is_idcode = (ir_q == `BSTA_OP_IDCODE);
  assign is_bsr = is_extest || (ir_q == `BSTA_OP_SAMPLE);

  // extest level handed to the clk side
  always_ff @(negedge tck) begin
    ext_tck_q <= is_extest;
  end

  // flips on each update so the clk side knows when the update word is settled
  always_ff @(negedge tck) begin
    if (in_tlr) begin
      upd_tgl_q <= 1'b0;
    end else if (cif.update_en) begin
      upd_tgl_q <= !upd_tgl_q;
    end
  end

  // idcode and bypass share the capture and shift states
  always_ff @(posedge tck) begin
    if (st_q == BSTA_CAP_DR) begin
      id_q <= ID_VALUE;
      byp_q <= 1'b0;
    end else if (st_q == BSTA_SH_DR) begin
      id_q <= {tdi, id_q[`BSTA_ID_W-1:1]};
      byp_q <= tdi;
    end
  end

  // the boundary chain only moves under the two boundary instructions
  assign cif.capture_en = (st_q == BSTA_CAP_DR) && is_bsr;
  assign cif.shift_en = (st_q == BSTA_SH_DR) && is_bsr;
  assign cif.update_en = (st_q == BSTA_UP_DR) && is_bsr;
  assign cif.scan_in = tdi;

  // pins come from outside the tck domain: two flops before the chain sees them
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      always_ff @(posedge tck) begin
        pin_s1_q[g] <= pin_in[g];
        pin_s2_q[g] <= pin_s1_q[g];
      end
      if (g < `BSTA_DIFF_PINS) begin : g_pair
        // after configuration a pair pin is an internal cell and reads 0
        assign pin_cap[g] = pin_s2_q[g] && !cfgd_s2_q;
      end else begin : g_single
        assign pin_cap[g] = pin_s2_q[g];
      end
    end
  endgenerate
  assign cif.pin_in = pin_cap;

  // tdo source follows the state first, then the instruction
  always_comb begin
    if (st_q == BSTA_SH_IR) begin
      sel_tdo = ir_sh_q[0];
    end else if (is_idcode) begin
      sel_tdo = id_q[0];
    end else if (is_bsr) begin
      sel_tdo = cif.scan_out;
    end else begin
      sel_tdo = byp_q;
    end
  end

  always_ff @(negedge tck) begin
    tdo <= sel_tdo;
  end

  // tdo is only driven while a register is being shifted
  always_ff @(negedge tck) begin
    tdo_oe_n <= !(st_q == BSTA_SH_IR || st_q == BSTA_SH_DR);
  end

  // system clock side: three flops on the extest and toggle levels, two on the others
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_tck_q;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      intr_s1_q <= 1'b0;
      intr_s2_q <= 1'b0;
    end else begin
      intr_s1_q <= intr_tck_q;
      intr_s2_q <= intr_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_c1_q <= 1'b0;
      busy_c2_q <= 1'b0;
    end else begin
      busy_c1_q <= refused_tck_q;
      busy_c2_q <= busy_c1_q;
    end
  end

  // the update word is read on extest entry, while ext_s3_q is still low, and after each toggle has passed two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= upd_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign upd_load = !ext_s3_q || (tgl_s3_q != tgl_s2_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      config_stop <= 1'b0;
    end else begin
      config_stop <= intr_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      extest_refused <= 1'b0;
    end else begin
      extest_refused <= busy_c2_q;
    end
  end

  // pins hold while extest waits for a settled update word
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else if (!ext_s2_q) begin
      pin_out <= core_out;
      pin_oe_n <= core_oe_n;
    end else if (upd_load) begin
      pin_out <= cif.data_upd;
      pin_oe_n <= cif.oe_upd;
    end
  end
endmodule // bsta_top
`default_nettype wire

// ===== dv/bsta_properties.sv
// Purpose: tap sequencing and configuration interlock properties
// Assumes: tck toggles only inside frames
// Notes: bound to bsta_top
`timescale 1ns/100ps
`default_nettype none
module bsta_properties (
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic config_busy,
  input wire logic config_stop,
  input wire logic extest_refused
);
  default clocking @(posedge tck); endclocking
  default disable iff (reset);
  sequence to_sir;
    tms[*5] ##1 !tms ##1 tms[*2] ##1 !tms[*2];
  endsequence
  ir_capture_a: assert property (to_sir |=> tdo)
    else $error("first ir bit not 1");
  ir_second_a: assert property (to_sir ##1 !tms |=> !tdo && !tdo_oe_n)
    else $error("second ir bit not 0");
  ir_third_a: assert property (to_sir ##1 !tms[*2] |=> !tdo)
    else $error("third ir bit not 0");
  tap_idle_a: assert property (tms[*7] |-> tdo_oe_n)
    else $error("tdo driven in reset state");
  stop_clear_a: assert property (tms[*8] |-> !config_stop)
    else $error("interrupt survives tap reset");
  stop_hold_a: assert property (config_stop && !tms |=> config_stop)
    else $error("interrupt dropped");
  refuse_busy_a: assert property ($rose(extest_refused) |-> config_busy)
    else $error("refusal while idle");
  refuse_stop_a: assert property ($rose(extest_refused) |-> !config_stop)
    else $error("refusal despite interrupt");
  cover property (to_sir);
  cover property ($rose(config_stop));
  cover property ($rose(extest_refused));
endmodule // bsta_properties
bind bsta_top bsta_properties bsta_properties_inst (.reset, .tck, .tms, .tdo,
  .tdo_oe_n, .config_busy, .config_stop, .extest_refused);
`default_nettype wire

// ===== dv/bsta_tester.sv
// Purpose: boundary-scan tester model
// Assumes: tck 32 ns, still between frames
// Notes: tdo sampled after the falling edge
`timescale 1ns/100ps
`default_nettype none
module bsta_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #8 tck = 1'b1;
    #16 tck = 1'b0;
    tdi = ~d; // released line does not keep its value
    #8 o = tdo;
  endtask
  task automatic tap_reset();
    logic o;
    repeat (8) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic load_ir(input logic [3:0] op, output logic [3:0] cap);
    logic o;
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    cap[0] = o;
    for (int i = 0; i < 4; i++) begin
      step(i == 3, op[i], o);
      if (i < 3) cap[i+1] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    dout[0] = o;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      if (i < n - 1) dout[i+1] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule // bsta_tester
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench of the scan access block
// Assumes: 8 pins, default instruction codes
// Notes: config side driven 2 ns after clk
`timescale 1ns/100ps
`default_nettype none
`include "bsta_cfg.svh"
module tb_top;
  logic clk, reset, config_busy, tck, tms, tdi, tdo, tdo_oe_n;
  logic config_stop, extest_refused;
  logic [7:0] pin_out, pin_oe_n;
  logic configured;
  logic [7:0] pin_in;
  logic [3:0] cap;
  logic [31:0] d;
  int fails = 0;
  int tests_run = 0;
  bsta_top #(.N(8)) bsta_top_inst (.clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
    .config_busy, .configured, .core_out(8'h00), .core_oe_n(8'hFF),
    .pin_in, .pin_out, .pin_oe_n, .config_stop, .extest_refused);
  bsta_tester bsta_tester_inst (.tck, .tms, .tdi, .tdo);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #2;
  endtask
  task automatic t_capture();
    bsta_tester_inst.tap_reset();
    bsta_tester_inst.load_ir(`BSTA_OP_IDCODE, cap);
    check(cap, 4'h1);
    bsta_tester_inst.scan_dr(32, 32'h0, d);
    check(d, `BSTA_IDCODE_RESET);
  endtask
  task automatic t_bypass();
    bsta_tester_inst.load_ir(`BSTA_OP_BYPASS, cap);
    bsta_tester_inst.scan_dr(8, 32'hB4, d);
    check(d, 32'h68);
  endtask
  task automatic t_refuse();
    bsta_tester_inst.load_ir(`BSTA_OP_SAMPLE, cap);
    bsta_tester_inst.scan_dr(16, 32'hAAAA, d);
    check(d, 32'h5555);
    @(posedge clk);
    #2;
    config_busy = 1'b1;
    bsta_tester_inst.load_ir(`BSTA_OP_EXTEST, cap);
    settle();
    check(extest_refused, 1'b1);
    check(pin_oe_n, 8'hFF);
  endtask
  task automatic t_extest();
    bsta_tester_inst.load_ir(`BSTA_OP_CFG_INTR, cap);
    settle();
    check(config_stop, 1'b1);
    bsta_tester_inst.load_ir(`BSTA_OP_EXTEST, cap);
    settle();
    check(extest_refused, 1'b0);
    check(pin_out, 8'hFF);
    check(pin_oe_n, 8'h00);
    bsta_tester_inst.tap_reset();
    settle();
    check(config_stop, 1'b0);
    check(pin_oe_n, 8'hFF);
    @(posedge clk);
    #2;
    config_busy = 1'b0;
  endtask
  task automatic t_diff();
    pin_in = 8'hFF;
    bsta_tester_inst.load_ir(`BSTA_OP_SAMPLE, cap);
    bsta_tester_inst.scan_dr(16, 32'hAAAA, d);
    check(d, 32'hFFFF);
    @(posedge clk);
    #2;
    configured = 1'b1;
    bsta_tester_inst.scan_dr(16, 32'hAAAA, d);
    check(d, 32'hAAA0);
  endtask
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    config_busy = 1'b0;
    configured = 1'b0;
    pin_in = 8'h00;
    repeat (6) @(posedge clk);
    #2 reset = 1'b0;
    check(pin_oe_n, 8'hFF);
    check(pin_out, 8'h00);
    t_capture();
    t_bypass();
    t_refuse();
    t_extest();
    t_diff();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
